/* src/usb_ep_pkg.sv */
// Constants and types shared by the endpoint responder and its transmit FIFO.
// Assumes one system clock; all token and packet strobes arrive already on it.

package usb_ep_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_EP     = 3;
    localparam int BUF_BYTES  = 8;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;

    localparam logic [3:0] MAX_PAYLOAD = 4'h8;
    localparam logic [3:0] CRC_BYTES   = 4'h2;
    localparam logic [3:0] ZERO_COUNT  = 4'h0;
    localparam logic [1:0] CTRL_EP     = 2'h0;

    // ****************************************
    // Processor IO map of the endpoint buffers
    // ****************************************
    localparam logic [7:0] IO_BUF_BASE          = 8'h50;
    localparam logic [7:0] IO_BUF_LAST          = 8'h67;
    localparam logic [7:0] ENDPOINT_TWO_BUFFER  = 8'h60;

    // ****************************************
    // Endpoint mode encodings
    // ****************************************
    localparam logic [3:0] MODE_DISABLE      = 4'h0;
    localparam logic [3:0] MODE_NAK_IN_OUT   = 4'h1;
    localparam logic [3:0] MODE_STATUS_OUT   = 4'h2;
    localparam logic [3:0] MODE_STALL_IN_OUT = 4'h3;
    localparam logic [3:0] MODE_STATUS_IN    = 4'h6;
    localparam logic [3:0] MODE_ACK_OUT_SIN  = 4'hB;
    localparam logic [3:0] MODE_ACK_IN_SOUT  = 4'hF;
    localparam logic [3:0] MODE_NAK_OUT      = 4'h8;
    localparam logic [3:0] MODE_ACK_OUT      = 4'h9;
    localparam logic [3:0] MODE_NAK_IN       = 4'hC;
    localparam logic [3:0] MODE_ACK_IN       = 4'hD;

    // ****************************************
    // Token, handshake and phase types
    // ****************************************
    typedef enum logic [1:0] {PID_SETUP, PID_IN, PID_OUT} pid_type;
    typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL} hs_type;
    typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_SEND} phase_type;

endpackage : usb_ep_pkg

/* src/usb_endpoint_mode_responder.sv */
// Endpoint response logic of the serial interface engine plus its byte FIFO.
// Assumes the token decoder, CRC check and bit-level transmitter sit outside
// on clk_sys and present tokens, bytes and host handshakes as strobes.

`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Transmit byte FIFO
// ****************************************
module usb_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // System
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_FILL = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               rd;
        logic [AW-1:0]               wr;
        logic [AW:0]                 fill;
    } fifo_state_type;

    fifo_state_type s;
    fifo_state_type next_s;
    logic           push;
    logic           pop;

    // Flags come straight from the fill count, so full and empty are exact
    assign in_ready  = s.fill != FULL_FILL;
    assign out_valid = s.fill != '0;
    assign out_data  = s.mem[s.rd];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // Pointers wrap naturally; depth must be a power of two
    always_comb
    begin
        next_s = s;
        if (push)
        begin
            next_s.mem[s.wr] = in_data;
            next_s.wr        = s.wr + 1'b1;
        end
        if (pop)
            next_s.rd = s.rd + 1'b1;
        next_s.fill = s.fill + (AW+1)'(push) - (AW+1)'(pop);
        if (rst)
        begin
            next_s     = '0;
            next_s.mem = s.mem; // Storage needs no reset
        end
    end

    always_ff @(posedge clk_sys)
    begin
        s <= next_s;
    end

endmodule : usb_byte_fifo

// ****************************************
// Endpoint mode responder
// ****************************************
module usb_endpoint_mode_responder
    import usb_ep_pkg::*;
(
    // System
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    // Processor IO space
    input  wire logic [7:0]              io_addr,
    input  wire logic                    io_wr,
    input  wire logic                    io_rd,
    input  wire logic [7:0]              io_wdata,
    output logic [7:0]                   io_rdata,
    // Endpoint control
    input  wire logic [NUM_EP-1:0]       mode_load,
    input  wire logic [3:0]              mode_value,
    input  wire logic [NUM_EP-1:0]       stall_flag,
    input  wire logic [NUM_EP-1:0][3:0]  tx_count,
    output logic [NUM_EP-1:0][3:0]       endpoint_mode,
    output logic [NUM_EP-1:0][3:0]       rx_count,
    // Tokens and received data
    input  wire logic                    tok_valid,
    input  wire pid_type                 tok_pid,
    input  wire logic [1:0]              tok_ep,
    input  wire logic                    rx_valid,
    input  wire logic [7:0]              rx_data,
    input  wire logic                    rx_end,
    input  wire logic                    rx_crc_ok,
    input  wire logic                    rx_toggle,
    input  wire logic                    host_ack,
    // Handshake and packet start
    output logic                         hs_valid,
    output hs_type                       hs_code,
    output logic                         pkt_start,
    output logic [3:0]                   pkt_len,
    // Transmit byte stream
    output logic                         tx_valid,
    input  wire logic                    tx_ready,
    output logic [7:0]                   tx_data
);

    typedef struct packed {
        phase_type                         phase;
        logic [NUM_EP-1:0][3:0]            mode;
        logic [NUM_EP-1:0][3:0]            rcount;
        logic [NUM_EP*BUF_BYTES-1:0][7:0]  buffer;
        pid_type                           rx_pid;
        logic [1:0]                        cur_ep;
        logic [3:0]                        rx_cnt;
        logic                              rx_over;
        logic                              rx_keep;
        logic [2:0]                        tx_idx;
        logic [3:0]                        tx_len;
        logic                              await_ack;
        logic [1:0]                        ack_ep;
        logic                              hs_valid;
        hs_type                            hs_code;
        logic                              pkt_start;
        logic [3:0]                        pkt_len;
        logic [7:0]                        io_rdata;
    } state_type;

    state_type         s;
    state_type         next_s;
    logic [1:0]        ep_sel;
    logic              ep_ok;
    logic [3:0]        cur_mode;
    logic              cur_stall;
    logic              ctrl;
    logic [3:0]        in_cnt;
    logic [4:0]        io_off;
    logic              io_hit;
    logic              fifo_in_ready;
    logic              do_hs;
    hs_type            resp;
    logic              mode_wr;
    logic [3:0]        new_mode;
    logic              send_pkt;
    logic [3:0]        send_len;
    logic [NUM_EP-1:0] sie_wr;

    // Modes that make a control endpoint take a SETUP
    function automatic logic setup_ok(input logic [3:0] m);
        setup_ok = (m == MODE_NAK_IN_OUT) || (m == MODE_STATUS_OUT) ||
                   (m == MODE_STALL_IN_OUT) || (m == MODE_STATUS_IN) ||
                   (m == MODE_ACK_OUT_SIN) || (m == MODE_ACK_IN_SOUT);
    endfunction : setup_ok

    // ****************************************
    // Endpoint selection and IO decode
    // ****************************************
    assign ep_sel    = (s.phase == ST_IDLE) ? tok_ep : s.cur_ep;
    assign ep_ok     = ep_sel < 2'(NUM_EP);
    assign cur_mode  = ep_ok ? s.mode[ep_sel] : MODE_DISABLE;
    assign cur_stall = ep_ok & stall_flag[ep_sel];
    assign ctrl      = ep_sel == CTRL_EP;
    assign in_cnt    = ep_ok ? tx_count[ep_sel] : ZERO_COUNT;
    assign io_off    = 5'(io_addr - IO_BUF_BASE);
    // Only the IO port reaches the buffers; there is no memory-space path
    assign io_hit    = (io_addr >= IO_BUF_BASE) && (io_addr <= IO_BUF_LAST);

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb
    begin
        next_s           = s;
        next_s.hs_valid  = 1'b0;
        next_s.pkt_start = 1'b0;
        do_hs            = 1'b0;
        resp             = HS_NAK;
        mode_wr          = 1'b0;
        new_mode         = cur_mode;
        send_pkt         = 1'b0;
        send_len         = ZERO_COUNT;
        sie_wr           = '0;

        // Processor side of the buffers; a same-cycle engine write lands later and wins
        if (io_wr && io_hit)
            next_s.buffer[io_off] = io_wdata;
        if (io_rd)
            next_s.io_rdata = io_hit ? s.buffer[io_off] : 8'h00;

        case (s.phase)
            ST_IDLE:
            begin
                // Host took the last IN data: data endpoint in ACK-IN or ep0 in ACK-IN-SOUT drops back to NAK
                if (host_ack && s.await_ack)
                begin
                    next_s.await_ack = 1'b0;
                    if (s.ack_ep != CTRL_EP && s.mode[s.ack_ep] == MODE_ACK_IN)
                    begin
                        next_s.mode[s.ack_ep] = MODE_NAK_IN;
                        sie_wr[s.ack_ep]      = 1'b1;
                    end
                    else if (s.ack_ep == CTRL_EP && s.mode[CTRL_EP] == MODE_ACK_IN_SOUT)
                    begin
                        next_s.mode[CTRL_EP] = MODE_NAK_IN_OUT;
                        sie_wr[CTRL_EP]      = 1'b1;
                    end
                end
                if (tok_valid && ep_ok)
                begin
                    next_s.cur_ep    = tok_ep;
                    next_s.await_ack = 1'b0;
                    if (tok_pid == PID_IN)
                    begin
                        // Unlisted and reserved modes fall to default: silence
                        if (ctrl)
                            case (cur_mode)
                                MODE_NAK_IN_OUT:   begin do_hs = 1'b1; resp = HS_NAK; end
                                MODE_STATUS_OUT:
                                begin
                                    do_hs    = 1'b1;
                                    resp     = HS_STALL;
                                    mode_wr  = 1'b1;
                                    new_mode = MODE_STALL_IN_OUT;
                                end
                                MODE_STALL_IN_OUT: begin do_hs = 1'b1; resp = HS_STALL; end
                                MODE_STATUS_IN:    send_pkt = 1'b1;
                                MODE_ACK_OUT_SIN:  send_pkt = 1'b1;
                                MODE_ACK_IN_SOUT:
                                begin
                                    send_pkt = 1'b1;
                                    send_len = in_cnt;
                                end
                                default:           do_hs = 1'b0;
                            endcase
                        else
                            case (cur_mode)
                                MODE_NAK_IN:       begin do_hs = 1'b1; resp = HS_NAK; end
                                MODE_ACK_IN:
                                    if (cur_stall)
                                    begin
                                        do_hs = 1'b1;
                                        resp  = HS_STALL;
                                    end
                                    else
                                    begin
                                        send_pkt = 1'b1;
                                        send_len = in_cnt;
                                    end
                                default:           do_hs = 1'b0;
                            endcase
                    end
                    else
                    begin
                        // SETUP or OUT: collect the data packet first
                        next_s.phase   = ST_RX;
                        next_s.rx_pid  = tok_pid;
                        next_s.rx_cnt  = ZERO_COUNT;
                        next_s.rx_over = 1'b0;
                        if (tok_pid == PID_SETUP)
                            next_s.rx_keep = ctrl && setup_ok(cur_mode);
                        else
                            next_s.rx_keep = (ctrl && cur_mode == MODE_ACK_OUT_SIN) ||
                                             (!ctrl && cur_mode == MODE_ACK_OUT && !cur_stall);
                    end
                end
            end
            ST_RX:
            begin
                if (rx_valid)
                begin
                    if (s.rx_cnt == MAX_PAYLOAD)
                        next_s.rx_over = 1'b1;
                    else
                    begin
                        if (s.rx_keep)
                            next_s.buffer[{s.cur_ep, s.rx_cnt[2:0]}] = rx_data;
                        next_s.rx_cnt = s.rx_cnt + 4'h1;
                    end
                end
                if (rx_end)
                begin
                    next_s.phase = ST_IDLE;
                    // Bad CRC or more than eight bytes: no answer at all
                    if (rx_crc_ok && !s.rx_over)
                    begin
                        if (s.rx_pid == PID_SETUP)
                        begin
                            if (ctrl && setup_ok(cur_mode))
                            begin
                                do_hs    = 1'b1;
                                resp     = HS_ACK;
                                mode_wr  = 1'b1;
                                new_mode = MODE_NAK_IN_OUT;
                                next_s.rcount[s.cur_ep] = s.rx_cnt + CRC_BYTES;
                            end
                        end
                        else if (ctrl)
                            case (cur_mode)
                                MODE_NAK_IN_OUT:   begin do_hs = 1'b1; resp = HS_NAK; end
                                MODE_STALL_IN_OUT: begin do_hs = 1'b1; resp = HS_STALL; end
                                MODE_STATUS_IN:    begin do_hs = 1'b1; resp = HS_STALL; end
                                MODE_ACK_OUT_SIN:
                                begin
                                    do_hs = 1'b1;
                                    resp  = HS_ACK;
                                    next_s.rcount[s.cur_ep] = s.rx_cnt + CRC_BYTES;
                                end
                                MODE_STATUS_OUT, MODE_ACK_IN_SOUT:
                                begin
                                    do_hs   = 1'b1;
                                    mode_wr = 1'b1;
                                    if (s.rx_cnt == ZERO_COUNT && rx_toggle)
                                    begin
                                        resp     = HS_ACK;
                                        new_mode = MODE_STATUS_OUT;
                                        next_s.rcount[s.cur_ep] = CRC_BYTES;
                                    end
                                    else
                                    begin
                                        resp     = HS_STALL;
                                        new_mode = MODE_STALL_IN_OUT;
                                    end
                                end
                                default:           do_hs = 1'b0;
                            endcase
                        else
                            case (cur_mode)
                                MODE_NAK_OUT:      begin do_hs = 1'b1; resp = HS_NAK; end
                                MODE_ACK_OUT:
                                begin
                                    do_hs = 1'b1;
                                    if (cur_stall)
                                        resp = HS_STALL;
                                    else
                                    begin
                                        resp     = HS_ACK;
                                        mode_wr  = 1'b1;
                                        new_mode = MODE_NAK_OUT;
                                        next_s.rcount[s.cur_ep] = s.rx_cnt + CRC_BYTES;
                                    end
                                end
                                default:           do_hs = 1'b0;
                            endcase
                    end
                end
            end
            ST_SEND:
            begin
                // FIFO back-pressure holds the byte index here
                if (fifo_in_ready)
                begin
                    next_s.tx_idx = s.tx_idx + 3'h1;
                    if ({1'b0, s.tx_idx} == s.tx_len - 4'h1)
                        next_s.phase = ST_IDLE;
                end
            end
            default: next_s.phase = ST_IDLE;
        endcase

        // Handshake and mode rewrite from the engine
        if (do_hs)
        begin
            next_s.hs_valid = 1'b1;
            next_s.hs_code  = resp;
        end
        if (mode_wr)
        begin
            next_s.mode[ep_sel] = new_mode;
            sie_wr[ep_sel]      = 1'b1;
        end

        // Data packet start; a count above eight is clipped to the buffer size
        if (send_pkt)
        begin
            next_s.pkt_start = 1'b1;
            next_s.pkt_len   = (send_len > MAX_PAYLOAD) ? MAX_PAYLOAD : send_len;
            next_s.tx_len    = next_s.pkt_len;
            next_s.tx_idx    = 3'h0;
            next_s.await_ack = 1'b1;
            next_s.ack_ep    = tok_ep;
            if (next_s.pkt_len != ZERO_COUNT)
                next_s.phase = ST_SEND;
        end

        // Software mode loads lose to an engine rewrite in the same cycle
        for (int i = 0; i < NUM_EP; i++)
        begin
            if (mode_load[i] && !sie_wr[i])
                next_s.mode[i] = mode_value;
        end

        if (rst)
        begin
            next_s        = '0;
            next_s.buffer = s.buffer;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        s <= next_s;
    end

    // ****************************************
    // Transmit FIFO and outputs
    // ****************************************
    usb_byte_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (s.phase == ST_SEND),
        .in_ready  (fifo_in_ready),
        .in_data   (s.buffer[{s.cur_ep, s.tx_idx}]),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data)
    );

    assign io_rdata      = s.io_rdata;
    assign endpoint_mode = s.mode;
    assign rx_count      = s.rcount;
    assign hs_valid      = s.hs_valid;
    assign hs_code       = s.hs_code;
    assign pkt_start     = s.pkt_start;
    assign pkt_len       = s.pkt_len;

endmodule : usb_endpoint_mode_responder

`default_nettype wire

/* testbench/usb_ep_props.sv */
// Checker for the endpoint responder, bound to its ports.
// Assumes tokens come only while the engine is idle.
`timescale 1ns/1ps
`default_nettype none
module usb_ep_props
    import usb_ep_pkg::*;
(
    input wire logic            clk_sys, rst, io_rd, tok_valid, rx_end, host_ack, hs_valid, pkt_start,
    input wire logic [7:0]      io_addr, io_rdata,
    input wire logic [2:0]      mode_load, stall_flag,
    input wire logic [2:0][3:0] tx_count, endpoint_mode, rx_count,
    input wire pid_type         tok_pid,
    input wire logic [1:0]      tok_ep,
    input wire hs_type          hs_code,
    input wire logic [3:0]      pkt_len
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // IN token to endpoint one in acknowledge-IN mode
    wire tok_in1 = tok_valid && !rx_end && tok_pid == PID_IN && tok_ep == 2'h1 && endpoint_mode[1] == MODE_ACK_IN;
    quiet_modes_a: assert property (tok_valid && !rx_end && tok_ep != 2'h3 &&
        endpoint_mode[tok_ep] inside {4'h0, 4'h4, 4'h5, 4'h7, 4'hA, 4'hE} |=> !hs_valid && !pkt_start)
        else $error("ignored mode answered");
    nak_in_a: assert property (tok_valid && !rx_end && tok_pid == PID_IN && tok_ep == 2'h0 &&
        endpoint_mode[0] == MODE_NAK_IN_OUT |=> hs_valid && hs_code == HS_NAK) else $error("no NAK");
    stall_in_a: assert property (tok_in1 && stall_flag[1] |=> hs_valid && hs_code == HS_STALL)
        else $error("no STALL");
    counted_len_a: assert property (tok_in1 && !stall_flag[1] |=> pkt_start &&
        pkt_len == ($past(tx_count[1]) > 4'h8 ? 4'h8 : $past(tx_count[1]))) else $error("bad length");
    ack_to_nak_a: assert property (endpoint_mode[1] == MODE_ACK_IN && host_ack && !mode_load[1]
        |=> endpoint_mode[1] == MODE_NAK_IN) else $error("mode not 1100");
    out_ack_mode_a: assert property ((endpoint_mode[2] == MODE_ACK_OUT && !mode_load[2]) ##1
        endpoint_mode[2] == MODE_NAK_OUT |-> hs_valid && hs_code == HS_ACK) else $error("mode change w/o ACK");
    rx_count_a: assert property ($changed(rx_count[2]) |-> hs_valid && hs_code == HS_ACK &&
        rx_count[2] >= CRC_BYTES) else $error("bad count");
    rd_unmapped_a: assert property (io_rd && io_addr < IO_BUF_BASE |=> io_rdata == 8'h00)
        else $error("unmapped read");
    cover property (tok_in1 ##1 pkt_start);
    cover property (hs_valid && hs_code == HS_STALL);
    cover property (host_ack);
endmodule : usb_ep_props
bind usb_endpoint_mode_responder usb_ep_props props_u (.*);
`default_nettype wire

/* testbench/usb_host_model.sv */
// Host sink for IN payload bytes; stalls two of every four cycles.
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
    input wire logic       clk_sys, rst, tx_valid,
    input wire logic [7:0] tx_data,
    output logic           tx_ready
);
    logic [1:0] ph = 2'h0;
    logic [7:0] got[$];
    // Slow host keeps bytes waiting in the FIFO
    always_ff @(posedge clk_sys)
    begin
        ph <= rst ? 2'h0 : ph + 2'h1;
        if (!rst && tx_valid && tx_ready) got.push_back(tx_data);
    end
    assign tx_ready = ph[1];
endmodule : usb_host_model
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench: IO buffers, twelve ep0 mode codes (not 8, 9, C, D), data endpoints.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import usb_ep_pkg::*;
    logic clk_sys = 0, rst = 1, io_wr = 0, io_rd = 0, tok_valid = 0, rx_valid = 0, rx_end = 0;
    logic rx_crc_ok = 1, rx_toggle = 0, host_ack = 0, hs_valid, pkt_start, tx_valid, tx_ready;
    logic [7:0] io_addr = 0, io_wdata = 0, rx_data = 0, io_rdata, tx_data, r, d[8], bq[16];
    logic [2:0] mode_load = 0, stall_flag = 0;
    logic [3:0] mode_value = 0, pkt_len, c;
    logic [2:0][3:0] tx_count = 0, endpoint_mode, rx_count;
    logic [1:0] tok_ep = 0;
    pid_type tok_pid = PID_IN;
    hs_type hs_code;
    logic [3:0] modes[12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'hB, 4'hF, 4'h4, 4'h5, 4'h7, 4'hA, 4'hE};
    int bad_count = 0, n_checks = 0, cyc = 0;
    usb_endpoint_mode_responder dut_u (.*);
    usb_host_model host_u (.*);
    task automatic tick(); @(posedge clk_sys); #10; endtask : tick
    task automatic chk(input logic [7:0] s, e);
        n_checks++;
        if (s !== e) begin bad_count++; $display("[FAIL] %0t seen %h expected %h", $time, s, e); end
    endtask : chk
    task automatic load(input int ep, input logic [3:0] m);
        mode_load = 3'(1 << ep); mode_value = m; tick(); mode_load = 0;
    endtask : load
    task automatic wr(input logic [7:0] a, v);
        io_addr = a; io_wdata = v; io_wr = 1; tick(); io_wr = 0; tick();
    endtask : wr
    task automatic rd(input logic [7:0] a, e);
        io_addr = a; io_rd = 1; tick(); io_rd = 0; tick(); chk(io_rdata, e);
    endtask : rd
    // Token, optional data packet, then code the one-cycle answer right after its edge
    task automatic xfer(input pid_type p, input logic [1:0] ep, input int n, input logic ok, tg);
        tok_pid = p; tok_ep = ep; tok_valid = 1; tick(); tok_valid = 0;
        for (int i = 0; i < n; i++) begin bq[i] = 8'($urandom); rx_data = bq[i]; rx_valid = 1; tick(); end
        rx_valid = 0;
        if (p != PID_IN) begin rx_crc_ok = ok; rx_toggle = tg; rx_end = 1; tick(); rx_end = 0; end
        r = hs_valid ? 8'(hs_code) + 8'h1 : pkt_start ? 8'h8 + 8'(pkt_len) : 8'h0;
        repeat (20) tick();
    endtask : xfer
    // Expected IN answer of the control endpoint
    function automatic logic [7:0] exp_in(logic [3:0] m, cn);
        case (m)
            4'h1: return 8'h2;
            4'h2, 4'h3: return 8'h3;
            4'h6, 4'hB: return 8'h8;
            4'hF: return 8'h8 + 8'(cn);
            default: return 8'h0;
        endcase
    endfunction : exp_in
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    initial forever #50 clk_sys = ~clk_sys;
    // Hang guard, far above the roughly 700 cycles needed
    always @(posedge clk_sys) if (++cyc == 5000) begin bad_count++; complete_run(); end
    initial
    begin
        void'($urandom(32'h89e1));
        repeat (2) tick();
        rst = 0;
        for (int i = 0; i < 8; i++) begin d[i] = 8'($urandom); wr(8'(8'h60 + i), d[i]); wr(8'(8'h58 + i), ~d[i]); end
        for (int i = 0; i < 8; i++) rd(8'(8'h60 + i), d[i]);
        wr(8'h40, 8'hA5);
        rd(8'h40, 8'h00);
        $display("io test done");
        foreach (modes[k]) begin c = 4'($urandom_range(8)); tx_count[0] = c; load(0, modes[k]);
            xfer(PID_IN, 0, 0, 1, 1); chk(r, exp_in(modes[k], c)); end
        load(0, 4'h3); xfer(PID_OUT, 0, 1, 1, 1); chk(r, 8'h3);
        load(0, 4'h6); xfer(PID_OUT, 0, 1, 1, 1); chk(r, 8'h3);
        load(0, 4'hB); xfer(PID_OUT, 0, 2, 1, 0); chk(r, 8'h1);
        load(0, 4'hF); xfer(PID_OUT, 0, 0, 1, 0); chk(r, 8'h3);
        load(0, 4'h2); xfer(PID_OUT, 0, 0, 1, 1); chk(r, 8'h1);
        xfer(PID_SETUP, 0, 8, 1, 0); chk(8'(endpoint_mode[0]), 8'(MODE_NAK_IN_OUT));
        $display("control test done");
        tx_count[1] = 4'h3; load(1, MODE_ACK_IN); stall_flag = 3'h2;
        xfer(PID_IN, 1, 0, 1, 1); chk(r, 8'h3);
        stall_flag = 0; host_u.got.delete();
        xfer(PID_IN, 1, 0, 1, 1); chk(r, 8'hB);
        for (int i = 0; i < 3; i++) chk(host_u.got[i], ~d[i]);
        host_ack = 1; tick(); host_ack = 0; tick(); chk(8'(endpoint_mode[1]), 8'(MODE_NAK_IN));
        xfer(PID_IN, 1, 0, 1, 1); chk(r, 8'h2);
        xfer(PID_OUT, 1, 1, 1, 1); chk(r, 8'h0);
        load(2, MODE_ACK_OUT); xfer(PID_OUT, 2, 3, 1, 0); chk(r, 8'h1);
        chk(8'(endpoint_mode[2]), 8'(MODE_NAK_OUT)); chk(8'(rx_count[2]), 8'h5);
        for (int i = 0; i < 3; i++) rd(8'(8'h60 + i), bq[i]);
        xfer(PID_OUT, 2, 2, 1, 0); chk(r, 8'h2);
        load(2, MODE_ACK_OUT); stall_flag = 3'h4; xfer(PID_OUT, 2, 1, 1, 0); chk(r, 8'h3);
        stall_flag = 0; xfer(PID_OUT, 2, 9, 1, 0); chk(r, 8'h0);
        xfer(PID_OUT, 2, 2, 0, 0); chk(r, 8'h0);
        $display("data test done");
        complete_run();
    end
endmodule : tb
`default_nettype wire
